// File: hdl/irp_pkg.sv
package irp_pkg;
	// block geometry: square coding unit, one residual sample per cycle
	localparam int BLK_SIZE   = 8;
	localparam int BLK_LOG2   = 3;
	localparam int BLK_AREA   = BLK_SIZE * BLK_SIZE;
	localparam int ADDR_W     = 6;
	localparam logic [11:0] BLK_HALF = 12'h004;

	// sample widths
	localparam int DEPTH_W    = 8;
	localparam int RES_W      = 9;
	localparam int DIFF_W     = 10;
	localparam int COORD_W    = 12;
	localparam int REF_COORD_W = 13;

	// depth to disparity: disp = (depth * scale + offset) >>> DISP_SHIFT, quarter-sample units
	localparam int DISP_W     = 12;
	localparam int DISP_SHIFT = 8;
	localparam int FRAC_W     = 2;
	localparam int PROD_W     = 24;

	// bilinear weights for quarter positions
	localparam logic signed [3:0] WEIGHT_ONE = 4'sh4;
	localparam logic signed [12:0] ROUND_ADD = 13'sh0002;

	localparam logic [ADDR_W-1:0] LAST_IDX = 6'h3F;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_DEPTH  = 7'h02,
		ST_CONV   = 7'h04,
		ST_FETCH  = 7'h08,
		ST_DRAIN  = 7'h10,
		ST_DECIDE = 7'h20,
		ST_STREAM = 7'h40
	} state_t;
endpackage

// File: hdl/res_mem_if.sv
`timescale 1ns/100ps
// carries the reference residual block between the control logic and its store
interface res_mem_if;
	logic                                 wr_en;
	logic [irp_pkg::ADDR_W-1:0]           wr_addr;
	logic signed [irp_pkg::RES_W-1:0]     wr_data;
	logic [irp_pkg::ADDR_W-1:0]           rd_addr;
	logic signed [irp_pkg::RES_W-1:0]     rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// File: hdl/ref_res_mem.sv
`timescale 1ns/100ps
module ref_res_mem
(
	input  wire logic ref_clk,
	res_mem_if.mem    port
);
	logic signed [irp_pkg::RES_W-1:0] store [irp_pkg::BLK_AREA];

	// no reset on the array: contents are always written before a prediction uses them
	// read data is registered, so it lines up with the delayed current sample
	always_ff @(posedge ref_clk)
	begin
		port.rd_data <= store[port.rd_addr];
		if (port.wr_en)
			store[port.wr_addr] <= port.wr_data;
	end
endmodule

// File: hdl/interview_residual_predict.sv
`timescale 1ns/100ps
module interview_residual_predict
(
	input  wire logic                                  ref_clk,
	input  wire logic                                  reset_n,
	input  wire logic                                  blk_start,
	input  wire logic [irp_pkg::COORD_W-1:0]           blk_x,
	input  wire logic [irp_pkg::COORD_W-1:0]           blk_y,
	input  wire logic                                  depth_component,
	input  wire logic signed [7:0]                     depth_scale,
	input  wire logic signed [15:0]                    depth_offset,
	output logic                                       depth_rd_req,
	output logic [irp_pkg::COORD_W-1:0]                depth_rd_x,
	output logic [irp_pkg::COORD_W-1:0]                depth_rd_y,
	input  wire logic [irp_pkg::DEPTH_W-1:0]           depth_rd_data,
	output logic                                       ref_rd_req,
	output logic signed [irp_pkg::REF_COORD_W-1:0]     ref_rd_x,
	output logic signed [irp_pkg::REF_COORD_W-1:0]     ref_rd_y,
	input  wire logic signed [irp_pkg::RES_W-1:0]      ref_rd_data0,
	input  wire logic signed [irp_pkg::RES_W-1:0]      ref_rd_data1,
	output logic                                       flag_present,
	input  wire logic                                  usage_flag_valid,
	input  wire logic                                  usage_flag,
	input  wire logic                                  cur_res_valid,
	input  wire logic signed [irp_pkg::RES_W-1:0]      cur_res,
	output logic                                       out_valid,
	output logic signed [irp_pkg::DIFF_W-1:0]          out_res,
	output logic                                       out_last,
	output logic                                       out_pred_used,
	output logic                                       busy
);
	irp_pkg::state_t state;
	irp_pkg::state_t next_state;

	res_mem_if mem_bus ();

	logic [irp_pkg::COORD_W-1:0]           blk_x_r;
	logic [irp_pkg::COORD_W-1:0]           blk_y_r;
	logic signed [irp_pkg::DISP_W-1:0]     disp;
	logic [irp_pkg::ADDR_W-1:0]            fetch_idx;
	logic [irp_pkg::ADDR_W-1:0]            req_idx;
	logic                                  ret_valid;
	logic [irp_pkg::ADDR_W-1:0]            ret_idx;
	logic                                  nonzero;
	logic                                  use_pred;
	logic [irp_pkg::ADDR_W-1:0]            stream_idx;
	logic                                  v_d;
	logic                                  last_d;
	logic signed [irp_pkg::RES_W-1:0]      cur_d;

	// row and column of a sample inside the block, raster order
	function automatic logic [irp_pkg::COORD_W-1:0] idx_col(input logic [irp_pkg::ADDR_W-1:0] i);
		idx_col = {9'h000, i[irp_pkg::BLK_LOG2-1:0]};
	endfunction
	function automatic logic [irp_pkg::COORD_W-1:0] idx_row(input logic [irp_pkg::ADDR_W-1:0] i);
		idx_row = {9'h000, i[irp_pkg::ADDR_W-1:irp_pkg::BLK_LOG2]};
	endfunction

	// depth to disparity, quarter-sample result; scale and offset carry the camera set-up
	// both factors widen before the product, otherwise it would wrap at nine bits
	wire signed [irp_pkg::PROD_W-1:0] disp_full = irp_pkg::PROD_W'($signed({1'b0, depth_rd_data}))
		* irp_pkg::PROD_W'(depth_scale) + irp_pkg::PROD_W'(depth_offset);
	wire signed [irp_pkg::DISP_W-1:0] next_disp =
		disp_full[irp_pkg::DISP_SHIFT+irp_pkg::DISP_W-1:irp_pkg::DISP_SHIFT];

	// reference block origin: integer part of the disparity added to the block corner's x; y is the corner's own y
	wire signed [irp_pkg::DISP_W-3:0]       disp_int = disp[irp_pkg::DISP_W-1:irp_pkg::FRAC_W];
	wire [irp_pkg::FRAC_W-1:0]              disp_frac = disp[irp_pkg::FRAC_W-1:0];
	wire signed [irp_pkg::REF_COORD_W-1:0]  base_x = $signed({1'b0, blk_x_r})
		+ irp_pkg::REF_COORD_W'(disp_int);
	wire signed [irp_pkg::REF_COORD_W-1:0]  base_y = $signed({1'b0, blk_y_r});

	// bilinear blend; a zero fraction gives the left sample exactly
	wire signed [3:0]  w_right = $signed({2'b00, disp_frac});
	wire signed [3:0]  w_left = irp_pkg::WEIGHT_ONE - w_right;
	wire signed [12:0] interp_sum = 13'(w_left) * 13'(ref_rd_data0)
		+ 13'(w_right) * 13'(ref_rd_data1) + irp_pkg::ROUND_ADD;
	wire signed [irp_pkg::RES_W-1:0] interp = interp_sum[irp_pkg::RES_W+1:2];

	wire fetch_done = (state == irp_pkg::ST_DRAIN) && !ref_rd_req && !ret_valid;
	wire cur_take = (state == irp_pkg::ST_STREAM) && cur_res_valid;
	wire signed [irp_pkg::DIFF_W-1:0] cur_ext = irp_pkg::DIFF_W'(cur_d);
	wire signed [irp_pkg::DIFF_W-1:0] ref_ext = irp_pkg::DIFF_W'(mem_bus.rd_data);
	wire signed [irp_pkg::DIFF_W-1:0] next_out = use_pred ? cur_ext - ref_ext : cur_ext;

	// the store is written as reference samples return and read in step with the stream
	assign mem_bus.wr_en   = ret_valid;
	assign mem_bus.wr_addr = ret_idx;
	assign mem_bus.wr_data = interp;
	assign mem_bus.rd_addr = stream_idx;

	ref_res_mem u_mem
	(
		.ref_clk (ref_clk),
		.port    (mem_bus)
	);

	// sequencing of one coding unit
	always_comb
	begin
		next_state = state;
		case (state)
			irp_pkg::ST_IDLE:
				if (blk_start)
					next_state = depth_component ? irp_pkg::ST_STREAM : irp_pkg::ST_DEPTH;
			irp_pkg::ST_DEPTH:  next_state = irp_pkg::ST_CONV;
			irp_pkg::ST_CONV:   next_state = irp_pkg::ST_FETCH;
			irp_pkg::ST_FETCH:
				if (fetch_idx == irp_pkg::LAST_IDX)
					next_state = irp_pkg::ST_DRAIN;
			irp_pkg::ST_DRAIN:
				if (fetch_done)
					next_state = nonzero ? irp_pkg::ST_DECIDE : irp_pkg::ST_STREAM;
			irp_pkg::ST_DECIDE:
				if (usage_flag_valid)
					next_state = irp_pkg::ST_STREAM;
			irp_pkg::ST_STREAM:
				if (cur_take && stream_idx == irp_pkg::LAST_IDX)
					next_state = irp_pkg::ST_IDLE;
			default:            next_state = irp_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= irp_pkg::ST_IDLE;
			busy  <= 1'b0;
		end
		else
		begin
			state <= next_state;
			busy  <= (next_state != irp_pkg::ST_IDLE);
		end
	end

	// block corner capture and the single middle-sample depth read
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			blk_x_r      <= 12'h000;
			blk_y_r      <= 12'h000;
			depth_rd_req <= 1'b0;
			depth_rd_x   <= 12'h000;
			depth_rd_y   <= 12'h000;
			disp         <= 12'h000;
		end
		else
		begin
			depth_rd_req <= (state == irp_pkg::ST_IDLE) && blk_start && !depth_component;
			if (state == irp_pkg::ST_IDLE && blk_start)
			begin
				blk_x_r    <= blk_x;
				blk_y_r    <= blk_y;
				depth_rd_x <= blk_x + irp_pkg::BLK_HALF;
				depth_rd_y <= blk_y + irp_pkg::BLK_HALF;
			end
			if (state == irp_pkg::ST_CONV)
				disp <= next_disp;
		end
	end

	// reference fetch: request one cycle after issue, data one cycle after request
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fetch_idx  <= 6'h00;
			req_idx    <= 6'h00;
			ref_rd_req <= 1'b0;
			ref_rd_x   <= 13'h0000;
			ref_rd_y   <= 13'h0000;
			ret_valid  <= 1'b0;
			ret_idx    <= 6'h00;
		end
		else
		begin
			ref_rd_req <= (state == irp_pkg::ST_FETCH);
			ret_valid  <= ref_rd_req;
			ret_idx    <= req_idx;
			if (state == irp_pkg::ST_FETCH)
			begin
				fetch_idx <= fetch_idx + 6'h01;
				req_idx   <= fetch_idx;
				ref_rd_x  <= base_x + $signed({1'b0, idx_col(fetch_idx)});
				ref_rd_y  <= base_y + $signed({1'b0, idx_row(fetch_idx)});
			end
			else
				fetch_idx <= 6'h00;
		end
	end

	// per coding unit decision; an absent flag counts as zero
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			nonzero      <= 1'b0;
			use_pred     <= 1'b0;
			flag_present <= 1'b0;
		end
		else
		begin
			if (state == irp_pkg::ST_IDLE && blk_start)
			begin
				nonzero  <= 1'b0;
				use_pred <= 1'b0;
			end
			else if (ret_valid && interp != 9'h000)
				nonzero <= 1'b1;
			if (fetch_done && nonzero)
				flag_present <= 1'b1;
			else if (state == irp_pkg::ST_DECIDE && usage_flag_valid)
				flag_present <= 1'b0;
			if (state == irp_pkg::ST_DECIDE && usage_flag_valid)
				use_pred <= (usage_flag == 1'b1);
			else if (fetch_done && !nonzero)
				use_pred <= 1'b0;
		end
	end

	// stream: the registered store read lines up with the delayed current sample
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stream_idx    <= 6'h00;
			v_d           <= 1'b0;
			last_d        <= 1'b0;
			cur_d         <= 9'h000;
			out_valid     <= 1'b0;
			out_res       <= 10'h000;
			out_last      <= 1'b0;
			out_pred_used <= 1'b0;
		end
		else
		begin
			v_d    <= cur_take;
			last_d <= cur_take && stream_idx == irp_pkg::LAST_IDX;
			if (cur_take)
			begin
				cur_d      <= cur_res;
				stream_idx <= stream_idx + 6'h01;
			end
			out_valid <= v_d;
			out_last  <= last_d;
			if (v_d)
			begin
				out_res       <= next_out;
				out_pred_used <= use_pred;
			end
		end
	end

	AST_MID_SAMPLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		depth_rd_req |-> depth_rd_x == blk_x_r + irp_pkg::BLK_HALF
			&& depth_rd_y == blk_y_r + irp_pkg::BLK_HALF)
		else $error("depth read not at block middle");

	AST_DEPTH_USED: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == irp_pkg::ST_CONV |=> disp == $past(next_disp) && $past(depth_rd_req, 2))
		else $error("disparity not taken from the depth read");

	AST_REF_ORIGIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == irp_pkg::ST_FETCH && fetch_idx == 6'h00
		|=> ref_rd_req && ref_rd_x == $past(base_x) && ref_rd_y == $past(base_y))
		else $error("reference origin wrong");

	AST_INTEGER_POS: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ret_valid && disp_frac == 2'h0 |-> mem_bus.wr_data == ref_rd_data0)
		else $error("integer position altered the reference sample");

	AST_DIFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
		v_d && use_pred |=> out_valid && out_res == $past(cur_ext) - $past(ref_ext))
		else $error("prediction difference wrong");

	AST_PASS: assert property (@(posedge ref_clk) disable iff (!reset_n)
		v_d && !use_pred |=> out_valid && out_res == $past(cur_ext) && !out_pred_used)
		else $error("residual not passed unchanged");

	AST_FLAG_NONZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(flag_present) |-> nonzero && state == irp_pkg::ST_DECIDE)
		else $error("flag asked for an all-zero reference");

	AST_ABSENT_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
		fetch_done && !nonzero |=> !use_pred && !flag_present && state == irp_pkg::ST_STREAM)
		else $error("absent flag not treated as zero");

	AST_DEPTH_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == irp_pkg::ST_IDLE && blk_start && depth_component
		|=> state == irp_pkg::ST_STREAM && !use_pred && !depth_rd_req)
		else $error("prediction active for depth component");

	AST_FRESH_CU: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == irp_pkg::ST_IDLE && blk_start |=> !use_pred && !nonzero)
		else $error("decision carried over between coding units");

	AST_USE_FLAG: assert property (@(posedge ref_clk) disable iff (!reset_n)
		state == irp_pkg::ST_DECIDE && usage_flag_valid |=> use_pred == $past(usage_flag))
		else $error("usage flag not applied");
endmodule

// File: verif/far_side_model.sv
`timescale 1ns/100ps
// stand-in for the depth estimate store and the reference residual buffer
module far_side_model
(
	input  wire logic                                   ref_clk,
	input  wire logic [7:0]                             depth_val,
	input  wire logic                                   zero_ref,
	input  wire logic                                   depth_rd_req,
	output logic [irp_pkg::DEPTH_W-1:0]                 depth_rd_data,
	input  wire logic                                   ref_rd_req,
	input  wire logic signed [irp_pkg::REF_COORD_W-1:0] ref_rd_x,
	input  wire logic signed [irp_pkg::REF_COORD_W-1:0] ref_rd_y,
	output logic signed [irp_pkg::RES_W-1:0]            ref_rd_data0,
	output logic signed [irp_pkg::RES_W-1:0]            ref_rd_data1
);
	// small residual range, so a difference always fits the output width
	function automatic logic signed [8:0] res_at(input int x, input int y);
		int v;
		v = ((x * 3 + y * 5) % 29) - 14;
		return v[8:0];
	endfunction

	initial
	begin
		depth_rd_data = 8'h00;
		ref_rd_data0 = 9'h000;
		ref_rd_data1 = 9'h000;
	end

	// answer one cycle after a request; otherwise invert, so late sampling shows
	always @(posedge ref_clk)
	begin
		depth_rd_data <= depth_rd_req ? depth_val : ~depth_rd_data;
		ref_rd_data0 <= ref_rd_req ? (zero_ref ? 9'h000 : res_at(ref_rd_x, ref_rd_y)) : ~ref_rd_data0;
		ref_rd_data1 <= ref_rd_req ? (zero_ref ? 9'h000 : res_at(ref_rd_x + 1, ref_rd_y)) : ~ref_rd_data1;
	end
endmodule

// File: verif/interview_residual_predict_tb.sv
`timescale 1ns/100ps
module interview_residual_predict_tb;
	logic               ref_clk = 1'b0;
	logic               reset_n = 1'b0;
	logic               blk_start = 1'b0;
	logic [11:0]        blk_x = 12'h000;
	logic [11:0]        blk_y = 12'h000;
	logic               depth_component = 1'b0;
	logic signed [7:0]  depth_scale = 8'h00;
	logic signed [15:0] depth_offset = 16'h0000;
	logic               usage_flag_valid = 1'b0;
	logic               usage_flag = 1'b0;
	logic               cur_res_valid = 1'b0;
	logic signed [8:0]  cur_res = 9'h000;
	logic [7:0]         depth_val = 8'h00;
	logic               zero_ref = 1'b0;
	logic               depth_rd_req, ref_rd_req, flag_present, out_valid, out_last;
	logic               out_pred_used, busy;
	logic [11:0]        depth_rd_x, depth_rd_y;
	logic [7:0]         depth_rd_data;
	logic signed [12:0] ref_rd_x, ref_rd_y;
	logic signed [8:0]  ref_rd_data0, ref_rd_data1;
	logic signed [9:0]  out_res;
	int                 failures = 0;
	int                 checks = 0;

	// 250 MHz
	always #2 ref_clk = ~ref_clk;

	interview_residual_predict uut (.ref_clk, .reset_n, .blk_start, .blk_x, .blk_y,
		.depth_component, .depth_scale, .depth_offset, .depth_rd_req, .depth_rd_x,
		.depth_rd_y, .depth_rd_data, .ref_rd_req, .ref_rd_x, .ref_rd_y, .ref_rd_data0,
		.ref_rd_data1, .flag_present, .usage_flag_valid, .usage_flag, .cur_res_valid,
		.cur_res, .out_valid, .out_res, .out_last, .out_pred_used, .busy);
	far_side_model partner (.ref_clk, .depth_val, .zero_ref, .depth_rd_req,
		.depth_rd_data, .ref_rd_req, .ref_rd_x, .ref_rd_y, .ref_rd_data0, .ref_rd_data1);

	task automatic close_out();
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// bounded wait on a design strobe: 0 depth read, 1 reference read, 2 flag
	task automatic wait_for(input int sel, input int lim);
		int   w;
		logic s;
		w = 0;
		s = 1'b0;
		while (s !== 1'b1 && w < lim)
		begin
			@(negedge ref_clk);
			s = (sel == 0) ? depth_rd_req : (sel == 1) ? ref_rd_req : flag_present;
			w++;
		end
		if (s !== 1'b1)
		begin
			failures++;
			$display("mismatch wait_%0d expected 1 seen 0", sel);
			close_out();
		end
	endtask

	// one coding unit end to end; expectations come from the bench's own arithmetic
	task automatic run_block(input int bx, by, dep, sc, off, input bit zr, dc, flag_val);
		int                disp, idp, fr, bl, n, w;
		bit                eff, seen;
		logic signed [9:0] expq [64];
		disp = (dep * sc + off) >>> 8;
		idp = disp >>> 2;
		fr = disp & 3;
		eff = flag_val && !zr && !dc;
		seen = 1'b0;
		for (int k = 0; k < 64; k++)
		begin
			bl = zr ? 0 : ((4 - fr) * int'(partner.res_at(bx + idp + k % 8, by + k / 8))
				+ fr * int'(partner.res_at(bx + idp + k % 8 + 1, by + k / 8)) + 2) >>> 2;
			expq[k] = eff ? 10'(k * 7 - 200 - bl) : 10'(k * 7 - 200);
		end
		@(posedge ref_clk);
		blk_start <= 1'b1;
		blk_x <= bx[11:0];
		blk_y <= by[11:0];
		depth_scale <= sc[7:0];
		depth_offset <= off[15:0];
		depth_component <= dc;
		zero_ref <= zr;
		depth_val <= dep[7:0];
		@(posedge ref_clk);
		blk_start <= 1'b0;
		if (dc)
		begin
			repeat (3)
			begin
				@(negedge ref_clk);
				seen |= (depth_rd_req !== 1'b0) || (ref_rd_req !== 1'b0);
			end
			chk("no_reads", 32'h0, 32'(seen));
		end
		else
		begin
			wait_for(0, 20);
			chk("depth_rd_x", 32'(bx + 4), 32'(depth_rd_x));
			chk("depth_rd_y", 32'(by + 4), 32'(depth_rd_y));
			chk("busy_run", 32'h1, 32'(busy));
			wait_for(1, 20);
			chk("ref_rd_x", 32'(bx + idp), 32'(ref_rd_x));
			chk("ref_rd_y", 32'(by), 32'(ref_rd_y));
			if (!zr)
			begin
				wait_for(2, 120);
				@(posedge ref_clk);
				usage_flag_valid <= 1'b1;
				usage_flag <= flag_val;
				@(posedge ref_clk);
				usage_flag_valid <= 1'b0;
			end
			else
			begin
				repeat (100)
				begin
					@(negedge ref_clk);
					seen |= (flag_present !== 1'b0);
				end
				chk("flag_present", 32'h0, 32'(seen));
			end
		end
		n = 0;
		w = 0;
		fork
			begin
				for (int k = 0; k < 64; k++)
				begin
					@(posedge ref_clk);
					cur_res_valid <= 1'b1;
					cur_res <= 9'(k * 7 - 200);
				end
				@(posedge ref_clk);
				cur_res_valid <= 1'b0;
			end
			while (n < 64 && w < 300)
			begin
				@(negedge ref_clk);
				w++;
				if (out_valid === 1'b1)
				begin
					chk("out_res", 32'(expq[n]), 32'(out_res));
					chk("out_pred_used", 32'(eff), 32'(out_pred_used));
					chk("out_last", 32'(n == 63), 32'(out_last));
					n++;
				end
			end
		join
		if (n < 64)
		begin
			failures++;
			$display("mismatch out_count expected 64 seen %0d", n);
			close_out();
		end
		chk("busy", 32'h0, 32'(busy));
	endtask

	task automatic scen_frac_use();
		run_block(16, 8, 200, 11, 128, 1'b0, 1'b0, 1'b1);
	endtask

	task automatic scen_whole_skip();
		run_block(24, 16, 128, 8, 0, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic scen_left_use();
		run_block(40, 0, 80, -6, 0, 1'b0, 1'b0, 1'b1);
	endtask

	task automatic scen_zero_ref();
		run_block(8, 32, 150, 9, 64, 1'b1, 1'b0, 1'b1);
	endtask

	task automatic scen_depth_pic();
		run_block(0, 0, 200, 11, 128, 1'b0, 1'b1, 1'b1);
	endtask

	initial
	begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		scen_frac_use();
		scen_whole_skip();
		scen_left_use();
		scen_zero_ref();
		scen_depth_pic();
		scen_frac_use();
		close_out();
	end
endmodule
